// >>> design/tx_hdr_pkg.sv
/*
  Shared constants and types of the transmit header builder: register
  offsets, field positions, reset values and the sequencer states.
  Assumes a 32-bit AXI4-Lite register window with byte addresses.
*/
`default_nettype none
package tx_hdr_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_IDPTR = 12'h004;
  localparam logic [11:0] OFS_LENS = 12'h008;
  localparam logic [11:0] OFS_MINLEN = 12'h00c;
  localparam logic [11:0] OFS_POS = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  localparam logic [11:0] OFS_LASTID = 12'h018;
  localparam logic [11:0] OFS_HDRMEM = 12'h100;
  // configuration word indices (offset / 4)
  localparam int NUM_CFG = 5;
  localparam int IDX_CTRL = 0;
  localparam int IDX_IDPTR = 1;
  localparam int IDX_LENS = 2;
  localparam int IDX_MINLEN = 3;
  localparam int IDX_POS = 4;
  // field positions
  localparam int CTRL_IPV6_BIT = 0;
  localparam int CTRL_IDEN_BIT = 1;
  localparam int CTRL_LENP_BIT = 2;
  localparam int CTRL_DEST_LSB = 4;
  localparam int CTRL_PTYPE_LSB = 12;
  localparam int LENS_UDP_LSB = 0;
  localparam int LENS_HLEN_LSB = 8;
  localparam int LENS_LHL_LSB = 16;
  localparam int MIN_LEN_LSB = 0;
  localparam int MIN_ADJ_LSB = 16;
  localparam int POS_LPOS_LSB = 0;
  localparam int POS_ID6_LSB = 8;
  // writable bits and reset values of the configuration words
  localparam logic [31:0] CFG_WMASK [NUM_CFG] = '{
    32'h0000_fff7, 32'h0000_fffc, 32'h00ff_7f3f, 32'hffff_0fff,
    32'h0000_3fff};
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  // packet shaping constants
  localparam logic [11:0] PAD_BIAS = 12'h030;
  localparam logic [8:0] V4_ID_BACK = 9'h010;
  localparam logic [7:0] DEST_ALLOWED = 8'h55;
  localparam logic [7:0] DEST_PKTID = 8'h01;
  localparam logic [3:0] PTYPE_MAX = 4'h7;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_IDWAIT = 3'b001,
    ST_HWAIT = 3'b010,
    ST_HDR = 3'b011,
    ST_PAY = 3'b100,
    ST_PAD = 3'b101,
    ST_DROP = 3'b110
  } state_t;
endpackage
`default_nettype wire

// >>> design/hdr_mem_if.sv
/*
  Port bundle between the header builder and its header word memory.
  Assumes one write port and one registered read port on one clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface hdr_mem_if #(parameter int W = 32, parameter int AW = 6);
  logic we;
  logic [AW-1:0] waddr;
  logic [W-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [W-1:0] rdata;
  modport mem (input we, input waddr, input wdata, input raddr,
               output rdata);
  modport user (output we, output waddr, output wdata, output raddr,
                input rdata);
endinterface
`default_nettype wire

// >>> design/hdr_mem.sv
/*
  Header word memory: one write port, one read port whose data come
  from a register one cycle after the address.
  Assumes a single clock; contents are undefined until written.
*/
`timescale 1ns/1ps
`default_nettype none
module hdr_mem #(
  parameter int W = 32,
  parameter int DEPTH = 64
) (
  input wire logic clk_i,
  hdr_mem_if.mem port
);
  logic [W-1:0] mem_r [DEPTH];

  always_ff @(posedge clk_i) begin
    if (port.we) begin
      mem_r[port.waddr] <= port.wdata;
    end
    port.rdata <= mem_r[port.raddr];
  end
endmodule // hdr_mem
`default_nettype wire

// >>> design/tx_packet_header_builder.sv
/*
  Transmit header builder: emits a connection's header bytes with an
  inserted identification and 802.3 length, passes the payload, pads to
  a minimum length and tags the packet with its destinations.
  Assumes synchronous inputs on core_clk_i, a synchronous external
  memory bank A for the identification counters, and an AXI4-Lite master.
*/
// Functional notes
// - identification written only while insert enable set
// - counter read from aligned dword, low 64K bank A
// - counter incremented and written back to same place
// - IPv4 gets low 16 counter bits only
// - insert disabled means no counter access
// - destination mask is multicast; zero deletes packet
// - bits 6, 4, 2 select link A, B, CPU
// - packet identifier destination excludes all others
// - packet type passed only to packet identifier
// - UDP header located by dword index
// - header length counts dwords of header words
// - zero pad to minimum minus 48; zero disables
// - link header length is emitted header bytes
// - length field present flag enables length fill
// - length is payload plus header minus adjust
// - length written at byte position from word zero
// - IPv6 identification written into selected dword
`timescale 1ns/1ps
`default_nettype none
module tx_packet_header_builder import tx_hdr_pkg::*; #(
  parameter int AW = 12,
  parameter int HDR_DEPTH = 64
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // AXI4-Lite register slave
  input wire logic [AW-1:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [AW-1:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  // packet start from the assembly scheduler
  input wire logic start_valid_i,
  input wire logic [10:0] start_len_i,
  output logic start_ready_o,
  // payload bytes
  input wire logic pay_valid_i,
  input wire logic [7:0] pay_data_i,
  output logic pay_ready_o,
  // finished packet bytes
  output logic out_valid_o,
  output logic [7:0] out_data_o,
  output logic out_last_o,
  input wire logic out_ready_i,
  output logic [7:0] out_dest_o,
  output logic [3:0] out_ptype_o,
  output logic out_ptype_vld_o,
  // external memory bank A, identification counters
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [15:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  input wire logic [31:0] mem_rdata_i,
  input wire logic mem_rvalid_i
);
  localparam int HW = $clog2(HDR_DEPTH);

  function automatic logic [31:0] apply_strb(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction

  // header bytes leave most significant byte of a dword first
  function automatic logic [7:0] byte_of(input logic [31:0] w,
      input logic [1:0] sel);
    return w[8*(3-sel) +: 8];
  endfunction

  logic [1:0] rst_sync_r;
  logic rst_n;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  hdr_mem_if #(.W(32), .AW(HW)) hm ();
  hdr_mem #(.W(32), .DEPTH(HDR_DEPTH)) u_hdr_mem (
    .clk_i(core_clk_i),
    .port(hm.mem)
  );

  // register slave
  logic [31:0] cfg_r [NUM_CFG];
  logic aw_got_r, w_got_r, awready_r, wready_r, bvalid_r, arready_r;
  logic rvalid_r;
  logic [AW-1:0] aw_addr_r;
  logic [31:0] w_data_r, rdata_r;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r, rresp_r;
  logic [15:0] sent_cnt_r, drop_cnt_r;
  logic [31:0] id_r;
  state_t state_r, state_nxt;

  logic aw_take, w_take, do_wr, ar_take, aw_got_nxt, w_got_nxt;
  logic [2:0] wr_idx, rd_idx;
  logic wr_cfg, wr_hdr, wr_ro, rd_cfg, rd_hdr, rd_stat, rd_lastid;
  logic [31:0] rd_word, status_word;
  assign aw_take = awvalid_i & awready_r;
  assign w_take = wvalid_i & wready_r;
  assign do_wr = aw_got_r & w_got_r & ~bvalid_r;
  assign aw_got_nxt = (aw_got_r | aw_take) & ~do_wr;
  assign w_got_nxt = (w_got_r | w_take) & ~do_wr;
  assign wr_idx = aw_addr_r[4:2];
  assign wr_cfg = (aw_addr_r[AW-1:5] == '0) && (wr_idx < 3'(NUM_CFG))
      && (aw_addr_r[1:0] == 2'b00);
  assign wr_ro = (aw_addr_r == AW'(OFS_STATUS)) ||
      (aw_addr_r == AW'(OFS_LASTID));
  assign wr_hdr = (aw_addr_r[AW-1:8] == (AW-8)'(OFS_HDRMEM[11:8])) &&
      (aw_addr_r[1:0] == 2'b00);
  // partial strobes cannot be merged into the memory, so they are dropped
  assign hm.we = do_wr & wr_hdr & (w_strb_r == 4'hf);
  assign hm.waddr = aw_addr_r[HW+1:2];
  assign hm.wdata = w_data_r;

  assign ar_take = arvalid_i & arready_r;
  assign rd_idx = araddr_i[4:2];
  assign rd_cfg = (araddr_i[AW-1:5] == '0) && (rd_idx < 3'(NUM_CFG))
      && (araddr_i[1:0] == 2'b00);
  assign rd_stat = araddr_i == AW'(OFS_STATUS);
  assign rd_lastid = araddr_i == AW'(OFS_LASTID);
  assign rd_hdr = (araddr_i[AW-1:8] == (AW-8)'(OFS_HDRMEM[11:8])) &&
      (araddr_i[1:0] == 2'b00);
  assign status_word = {sent_cnt_r, drop_cnt_r[14:0],
      state_r != ST_IDLE};
  assign rd_word = rd_cfg ? cfg_r[rd_idx] : rd_stat ? status_word :
      rd_lastid ? id_r : 32'h0000_0000;

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      aw_addr_r <= '0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awready_r <= ~aw_got_nxt;
      wready_r <= ~w_got_nxt;
      if (aw_take) begin
        aw_addr_r <= awaddr_i;
      end
      if (w_take) begin
        w_data_r <= wdata_i;
        w_strb_r <= wstrb_i;
      end
      if (do_wr) begin
        bvalid_r <= 1'b1;
        bresp_r <= (wr_cfg | wr_hdr | wr_ro) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready_i) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else begin
      arready_r <= ~(ar_take | (rvalid_r & ~rready_i));
      if (ar_take) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_word;
        rresp_r <= (rd_cfg | rd_stat | rd_lastid | rd_hdr) ?
            RESP_OKAY : RESP_SLVERR;
      end else if (rready_i) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  for (genvar i = 0; i < NUM_CFG; i++) begin : g_cfg
    always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
        cfg_r[i] <= CFG_RST;
      end else if (do_wr && wr_cfg && (wr_idx == 3'(i))) begin
        cfg_r[i] <= apply_strb(cfg_r[i], w_data_r, w_strb_r) &
            CFG_WMASK[i];
      end
    end
  end

  // connection descriptor fields
  logic ipv6, iden, lenp;
  logic [7:0] mask, lhl, len_pos;
  logic [3:0] ptype;
  logic [15:0] id_ptr, adjust;
  logic [5:0] udp_start, id6_pos;
  logic [6:0] hdr_len;
  logic [11:0] min_len;
  assign ipv6 = cfg_r[IDX_CTRL][CTRL_IPV6_BIT];
  assign iden = cfg_r[IDX_CTRL][CTRL_IDEN_BIT];
  assign lenp = cfg_r[IDX_CTRL][CTRL_LENP_BIT];
  assign mask = cfg_r[IDX_CTRL][CTRL_DEST_LSB +: 8];
  assign ptype = cfg_r[IDX_CTRL][CTRL_PTYPE_LSB +: 4];
  assign id_ptr = cfg_r[IDX_IDPTR][15:0];
  assign udp_start = cfg_r[IDX_LENS][LENS_UDP_LSB +: 6];
  assign hdr_len = cfg_r[IDX_LENS][LENS_HLEN_LSB +: 7];
  assign lhl = cfg_r[IDX_LENS][LENS_LHL_LSB +: 8];
  assign min_len = cfg_r[IDX_MINLEN][MIN_LEN_LSB +: 12];
  assign adjust = cfg_r[IDX_MINLEN][MIN_ADJ_LSB +: 16];
  assign len_pos = cfg_r[IDX_POS][POS_LPOS_LSB +: 8];
  assign id6_pos = cfg_r[IDX_POS][POS_ID6_LSB +: 6];

  // sequencer
  logic start_ready_r, pay_ready_r, out_valid_r, out_last_r;
  logic mem_req_r, mem_we_r, ptype_vld_r;
  logic [7:0] out_data_r, dest_r;
  logic [3:0] ptype_r;
  logic [15:0] mem_addr_r, len_val_r;
  logic [31:0] mem_wdata_r;
  logic [8:0] hb_idx_r;
  logic [10:0] pay_cnt_r;
  logic [11:0] pad_cnt_r;

  logic start_take, pay_take, out_free, drop, ld_hdr, ld_pay, ld_pad;
  logic ld_any, hb_last, tail_empty, out_valid_nxt, ptype_ok;
  logic hit_len_hi, hit_len_lo, hit_v4_hi, hit_v4_lo, hit_v6;
  logic [7:0] dest_eff, raw_byte, hdr_byte, out_data_nxt;
  logic [8:0] hb_end, hb_start, v4_pos, hb_idx_nxt;
  logic [11:0] tot_len, pad_lim, pad_need, pad_cnt_nxt;
  logic [10:0] pay_cnt_nxt;
  logic out_last_nxt;
  state_t after_hdr;

  assign start_take = start_valid_i & start_ready_r;
  assign pay_take = pay_valid_i & pay_ready_r;
  assign out_free = ~out_valid_r | out_ready_i;
  // identifier destination wins alone; reserved bits never deliver
  assign dest_eff = mask[0] ? DEST_PKTID :
      (mask & DEST_ALLOWED);
  assign drop = dest_eff == 8'h00;
  assign ptype_ok = mask[0] && (ptype <= PTYPE_MAX);
  assign hb_end = {hdr_len, 2'b00};
  assign hb_start = hb_end - {1'b0, lhl};
  assign tot_len = 12'(lhl) + 12'(start_len_i);
  assign pad_lim = min_len - PAD_BIAS;
  assign pad_need = (min_len > PAD_BIAS && pad_lim > tot_len) ?
      pad_lim - tot_len : 12'h000;
  assign v4_pos = {1'b0, udp_start, 2'b00} - V4_ID_BACK;

  assign hm.raddr = hb_idx_r[HW+1:2];
  assign raw_byte = byte_of(hm.rdata, hb_idx_r[1:0]);
  assign hit_len_hi = lenp && (hb_idx_r == {1'b0, len_pos});
  assign hit_len_lo = lenp && (hb_idx_r == {1'b0, len_pos} + 9'h001);
  assign hit_v4_hi = iden && !ipv6 && (hb_idx_r == v4_pos);
  assign hit_v4_lo = iden && !ipv6 && (hb_idx_r == v4_pos + 9'h001);
  assign hit_v6 = iden && ipv6 &&
      (hb_idx_r[8:2] == {1'b0, id6_pos});
  assign hdr_byte = hit_len_hi ? len_val_r[15:8] :
      hit_len_lo ? len_val_r[7:0] : hit_v4_hi ? id_r[15:8] :
      hit_v4_lo ? id_r[7:0] : hit_v6 ? byte_of(id_r, hb_idx_r[1:0]) :
      raw_byte;

  assign hb_last = (hb_idx_r + 9'h001) == hb_end;
  assign tail_empty = (pay_cnt_r == 11'h000) && (pad_cnt_r == 12'h000);
  assign after_hdr = (pay_cnt_r != 11'h000) ? ST_PAY :
      (pad_cnt_r != 12'h000) ? ST_PAD : ST_IDLE;
  assign ld_hdr = (state_r == ST_HDR) && out_free;
  assign ld_pay = (state_r == ST_PAY) && pay_take;
  assign ld_pad = (state_r == ST_PAD) && out_free;
  assign ld_any = ld_hdr | ld_pay | ld_pad;
  assign out_data_nxt = ld_hdr ? hdr_byte :
      ld_pay ? pay_data_i : 8'h00;
  assign out_last_nxt = ld_hdr ? (hb_last & tail_empty) :
      ld_pay ? (pay_cnt_r == 11'h001 && pad_cnt_r == 12'h000) :
      (pad_cnt_r == 12'h001);
  assign out_valid_nxt = ld_any | (out_valid_r & ~out_ready_i);
  assign hb_idx_nxt = start_take ? hb_start :
      ld_hdr ? hb_idx_r + 9'h001 : hb_idx_r;
  assign pay_cnt_nxt = start_take ? start_len_i :
      pay_take ? pay_cnt_r - 11'h001 : pay_cnt_r;
  assign pad_cnt_nxt = start_take ? pad_need :
      ld_pad ? pad_cnt_r - 12'h001 : pad_cnt_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_take) begin
          state_nxt = drop ? ST_DROP : iden ? ST_IDWAIT : ST_HWAIT;
        end
      end
      ST_IDWAIT: begin
        if (mem_rvalid_i) begin
          state_nxt = ST_HWAIT;
        end
      end
      ST_HWAIT: begin
        state_nxt = (hb_idx_r == hb_end) ? after_hdr : ST_HDR;
      end
      ST_HDR: begin
        if (ld_hdr) begin
          state_nxt = hb_last ? after_hdr :
              (hb_idx_r[1:0] == 2'b11) ? ST_HWAIT : ST_HDR;
        end
      end
      ST_PAY: begin
        if (pay_take && pay_cnt_r == 11'h001) begin
          state_nxt = (pad_cnt_r != 12'h000) ? ST_PAD : ST_IDLE;
        end
      end
      ST_PAD: begin
        if (ld_pad && pad_cnt_r == 12'h001) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_DROP: begin
        if (pay_cnt_r == 11'h000) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      hb_idx_r <= 9'h000;
      pay_cnt_r <= 11'h000;
      pad_cnt_r <= 12'h000;
      start_ready_r <= 1'b0;
      pay_ready_r <= 1'b0;
      out_valid_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      hb_idx_r <= hb_idx_nxt;
      pay_cnt_r <= pay_cnt_nxt;
      pad_cnt_r <= pad_cnt_nxt;
      start_ready_r <= (state_nxt == ST_IDLE) && !start_take;
      // half rate on payload keeps ready a flop without a skid buffer
      pay_ready_r <= (pay_cnt_nxt != 11'h000) &&
          (((state_nxt == ST_PAY) && !out_valid_nxt) ||
           (state_nxt == ST_DROP));
      out_valid_r <= out_valid_nxt;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      out_data_r <= 8'h00;
      out_last_r <= 1'b0;
      dest_r <= 8'h00;
      ptype_r <= 4'h0;
      ptype_vld_r <= 1'b0;
      len_val_r <= 16'h0000;
      sent_cnt_r <= 16'h0000;
      drop_cnt_r <= 16'h0000;
    end else begin
      if (ld_any) begin
        out_data_r <= out_data_nxt;
        out_last_r <= out_last_nxt;
      end
      if (start_take) begin
        dest_r <= dest_eff;
        ptype_r <= ptype_ok ? ptype : 4'h0;
        ptype_vld_r <= ptype_ok;
        len_val_r <= 16'(tot_len) - adjust;
        sent_cnt_r <= sent_cnt_r + {15'h0000, !drop};
        drop_cnt_r <= drop_cnt_r + {15'h0000, drop};
      end
    end
  end

  // counter read on start, increment written back on return
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mem_req_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_addr_r <= 16'h0000;
      mem_wdata_r <= 32'h0000_0000;
      id_r <= 32'h0000_0000;
    end else begin
      mem_req_r <= 1'b0;
      if (start_take && !drop && iden) begin
        mem_req_r <= 1'b1;
        mem_we_r <= 1'b0;
        mem_addr_r <= {id_ptr[15:2], 2'b00};
      end else if (state_r == ST_IDWAIT && mem_rvalid_i) begin
        id_r <= mem_rdata_i;
        mem_req_r <= 1'b1;
        mem_we_r <= 1'b1;
        mem_wdata_r <= mem_rdata_i + 32'h0000_0001;
      end
    end
  end

  assign awready_o = awready_r;
  assign wready_o = wready_r;
  assign bvalid_o = bvalid_r;
  assign bresp_o = bresp_r;
  assign arready_o = arready_r;
  assign rvalid_o = rvalid_r;
  assign rdata_o = rdata_r;
  assign rresp_o = rresp_r;
  assign start_ready_o = start_ready_r;
  assign pay_ready_o = pay_ready_r;
  assign out_valid_o = out_valid_r;
  assign out_data_o = out_data_r;
  assign out_last_o = out_last_r;
  assign out_dest_o = dest_r;
  assign out_ptype_o = ptype_r;
  assign out_ptype_vld_o = ptype_vld_r;
  assign mem_req_o = mem_req_r;
  assign mem_we_o = mem_we_r;
  assign mem_addr_o = mem_addr_r;
  assign mem_wdata_o = mem_wdata_r;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_id_return;
    state_r == ST_IDWAIT && mem_rvalid_i;
  endsequence
  sequence s_pad_load;
    state_r == ST_PAD && out_free;
  endsequence
  sequence s_start_noid;
    start_take && !iden;
  endsequence

  property p_no_id_access;
    s_start_noid |=> (!mem_req_o)[*4];
  endproperty
  a_no_id_access: assert property (p_no_id_access)
    else $error("counter touched with insert disabled");
  property p_id_writeback;
    s_id_return |=> mem_req_o && mem_we_o &&
        mem_wdata_o == $past(mem_rdata_i) + 32'h0000_0001;
  endproperty
  a_id_writeback: assert property (p_id_writeback)
    else $error("counter write-back wrong");
  property p_id_addr;
    mem_req_o |-> mem_addr_o[1:0] == 2'b00 &&
        mem_addr_o == {id_ptr[15:2], 2'b00};
  endproperty
  a_id_addr: assert property (p_id_addr)
    else $error("counter address wrong");
  property p_delete;
    start_take && mask == 8'h00 |=> state_r == ST_DROP ##1
        state_r != ST_HDR;
  endproperty
  a_delete: assert property (p_delete)
    else $error("zero mask not deleted");
  property p_pktid_alone;
    out_valid_o && out_dest_o[0] |-> out_dest_o[7:1] == 7'h00;
  endproperty
  a_pktid_alone: assert property (p_pktid_alone)
    else $error("identifier destination combined");
  property p_dest_legal;
    out_valid_o |-> (out_dest_o & ~DEST_ALLOWED) == 8'h00;
  endproperty
  a_dest_legal: assert property (p_dest_legal)
    else $error("reserved destination delivered");
  property p_ptype;
    out_ptype_vld_o |-> out_dest_o == DEST_PKTID &&
        out_ptype_o <= PTYPE_MAX;
  endproperty
  a_ptype: assert property (p_ptype)
    else $error("packet type outside identifier path");
  property p_pad_zero;
    s_pad_load |=> out_valid_o && out_data_o == 8'h00;
  endproperty
  a_pad_zero: assert property (p_pad_zero)
    else $error("pad byte not zero");
  property p_len_hi;
    ld_hdr && lenp && hb_idx_r == {1'b0, len_pos} && !hit_v6 |=>
        out_data_o == len_val_r[15:8];
  endproperty
  a_len_hi: assert property (p_len_hi)
    else $error("length high byte wrong");
endmodule // tx_packet_header_builder
`default_nettype wire

// >>> dv/bank_a_model.sv
/* identification counter store standing in for bank A; answers reads
   one to four cycles late. assumes one request pulse at a time */
`timescale 1ns/1ps
`default_nettype none
module bank_a_model (
  // requests from the builder
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [15:0] addr_i,
  input wire logic [31:0] wdata_i,
  // read answer
  output logic [31:0] rdata_o,
  output logic rvalid_o
);
  logic [31:0] m [16];
  logic [15:0] last_a;
  int reads, dly, sd;
  initial begin
    foreach (m[i]) m[i] = 32'h1234fffe;
    sd = 32'hbccf9f30;
    reads = 0;
    dly = 0;
    rvalid_o = 0;
    rdata_o = 0;
  end
  always @(posedge clk_i) begin
    rvalid_o <= 0;
    rdata_o <= ~rdata_o; // stale data never looks valid
    if (dly == 1) begin
      rvalid_o <= 1;
      rdata_o <= m[last_a[5:2]];
    end
    if (dly > 0) dly <= dly - 1;
    if (req_i) begin
      last_a <= addr_i;
      if (we_i) m[addr_i[5:2]] <= wdata_i;
      else begin
        reads <= reads + 1;
        dly <= 1 + ($random(sd) & 3);
      end
    end
  end
endmodule // bank_a_model
`default_nettype wire

// >>> dv/tx_packet_header_builder_tb.sv
/* bench of the header builder: registers over AXI4-Lite, random payload
   and out stalls. assumes bank_a_model holds the counters */
`timescale 1ns/1ps
`default_nettype none
module tx_packet_header_builder_tb import tx_hdr_pkg::*;;
  logic clk, rstn, awv, awr, wv, wr_, bv, brd, arv, arr, rv, rrd;
  logic sv, sr, pv, pr, ov, olast, ordy, ptv, mreq, mwe, mrv, v6;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd_, mrd, mwd, d;
  logic [1:0] bresp, rresp;
  logic [10:0] slen;
  logic [7:0] pd, od, dest, hb [16];
  logic [3:0] pt;
  logic [15:0] ma;
  logic [7:0] got [$], pay [$];
  int bad_count, checks, seed, n, c;
  tx_packet_header_builder tx_packet_header_builder_inst (
    .core_clk_i(clk), .resetn_i(rstn), .awaddr_i(awa), .awvalid_i(awv),
    .awready_o(awr), .wdata_i(wd), .wstrb_i(4'hf), .wvalid_i(wv),
    .wready_o(wr_), .bresp_o(bresp), .bvalid_o(bv), .bready_i(brd),
    .araddr_i(ara), .arvalid_i(arv), .arready_o(arr), .rdata_o(rd_),
    .rresp_o(rresp), .rvalid_o(rv), .rready_i(rrd), .start_valid_i(sv),
    .start_len_i(slen), .start_ready_o(sr), .pay_valid_i(pv),
    .pay_data_i(pd), .pay_ready_o(pr), .out_valid_o(ov), .out_data_o(od),
    .out_last_o(olast), .out_ready_i(ordy), .out_dest_o(dest),
    .out_ptype_o(pt), .out_ptype_vld_o(ptv), .mem_req_o(mreq),
    .mem_we_o(mwe), .mem_addr_o(ma), .mem_wdata_o(mwd),
    .mem_rdata_i(mrd), .mem_rvalid_i(mrv));
  bank_a_model bank_a_model_inst (.clk_i(clk), .req_i(mreq), .we_i(mwe),
    .addr_i(ma), .wdata_i(mwd), .rdata_o(mrd), .rvalid_o(mrv));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    awa <= a; wd <= v; awv <= 1; wv <= 1; brd <= 1;
    do begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wr_) wv <= 0;
    end while (!bv);
    d = bresp;
    brd <= 0;
  endtask
  task rd(input logic [11:0] a);
    @(posedge clk);
    ara <= a; arv <= 1; rrd <= 1;
    do begin
      @(posedge clk);
      if (arr) arv <= 0;
    end while (!rv);
    d = rd_;
    rrd <= 0;
  endtask
  // emitted byte k: header from byte 2, payload, then zero pad
  function automatic logic [7:0] expb(int k, logic f, logic [31:0] id);
    logic [15:0] l;
    l = n + 10;
    if (k >= 14) return (k < 14 + n) ? pay[k-14] : 8'h00;
    if (f && v6 && k > 1 && k < 6) return id[8*(5-k) +: 8];
    if (f && k == 2) return id[15:8];
    if (f && k == 3) return id[7:0];
    if (f && k == 12) return l[15:8];
    if (f && k == 13) return l[7:0];
    return hb[k+2];
  endfunction
  task pkt(input logic f, input logic col, input logic [31:0] id);
    pay = {};
    got = {};
    for (int i = 0; i < n; i++) pay.push_back($random(seed));
    @(posedge clk);
    sv <= 1; slen <= n[10:0];
    do @(posedge clk); while (!sr);
    sv <= 0;
    fork
      begin
        for (int i = 0; i < n; i++) begin
          pd <= pay[i]; pv <= 1;
          do @(posedge clk); while (!pr);
        end
        pv <= 0;
      end
      if (col) do begin
        @(posedge clk);
        if (ov && ordy) got.push_back(od);
        ordy <= $random(seed);
      end while (!(ov && ordy && olast));
    join
    repeat (20) @(posedge clk);
    if (col) chk(got.size(), (n > 46) ? 14 + n : 60);
    foreach (got[k])
      if (f || k < 2 || k > 3) chk(got[k], expb(k, f, id));
    $display("packet of %0d payload bytes done", n);
  endtask
  initial begin
    #500000;
    bad_count++;
    print_verdict;
  end
  initial begin
    seed = 32'hbccf9f30;
    {awv, wv, brd, arv, rrd, sv, pv, ordy, rstn, v6} = 0;
    {awa, ara, wd, slen, pd} = 0;
    repeat (5) @(posedge clk);
    rstn <= 1;
    repeat (4) @(posedge clk);
    wr(12'h020, 0);
    chk(d, RESP_SLVERR);
    wr(OFS_CTRL, 32'h0000_2506);
    wr(OFS_IDPTR, 32'h0000_0010);
    wr(OFS_LENS, 32'h000e_0405);
    wr(OFS_MINLEN, 32'h0004_006c);
    wr(OFS_POS, 32'h0000_010e);
    for (int w = 0; w < 4; w++) begin
      wr(OFS_HDRMEM + 12'(4 * w), $random(seed));
      {hb[4*w], hb[4*w+1], hb[4*w+2], hb[4*w+3]} = wd;
    end
    n = 1 + ($random(seed) & 31);
    pkt(1, 1, 32'h1234fffe);
    chk(dest, 8'h50);
    chk(ptv, 0);
    n = 46;
    pkt(1, 1, 32'h1234ffff);
    rd(OFS_LASTID);
    chk(d, 32'h1234ffff);
    chk(rresp, RESP_OKAY);
    chk(bank_a_model_inst.m[4], 32'h12350000);
    chk(bank_a_model_inst.last_a, 16'h0010);
    wr(OFS_CTRL, 32'h0000_2006);
    pkt(1, 0, 0);
    rd(OFS_STATUS);
    chk(d, 32'h0002_0002);
    chk(bank_a_model_inst.reads, 2);
    c = bank_a_model_inst.reads;
    wr(OFS_CTRL, 32'h0000_7010);
    n = 1 + ($random(seed) & 63);
    pkt(0, 1, 0);
    chk(bank_a_model_inst.reads, c);
    chk({ptv, pt, dest}, {1'b1, 4'h7, 8'h01});
    wr(OFS_CTRL, 32'h0000_0847);
    v6 = 1;
    n = 1 + ($random(seed) & 15);
    pkt(1, 1, 32'h1235_0000);
    chk(dest, 8'h04);
    chk(bank_a_model_inst.m[4], 32'h1235_0001);
    print_verdict;
  end
endmodule // tx_packet_header_builder_tb
`default_nettype wire
